// ===== sim/iasf_bus_model.sv
// Bus master model: START, address byte, STOP
`timescale 1ns/10ps
module iasf_bus_model (
  output reg scl,
  output reg sda
);
  // Idle bus pulled high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Hold START for h ns, then 64 ns SCL bits MSB first
  task frame(input [7:0] b, input integer h);
    integer i;
    begin
      sda = 1'b0;
      #(h) scl = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        #16 sda = b[i];
        #16 scl = 1'b1;
        #32 scl = 1'b0;
      end
      #16 sda = 1'b0;
      #16 scl = 1'b1;
      #16 sda = 1'b1;
    end
  endtask
endmodule

// ===== sim/iasf_top_assertions.sv
// Checker for the address match and START filter
`timescale 1ns/10ps
module iasf_chk (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire slave_mode,
  input wire scl_in,
  input wire sda_in,
  input wire start_valid_ff,
  input wire intr_set_ff,
  input wire addr_match_ff,
  input wire [7:0] addr_byte_ff,
  input wire addr_byte_valid_ff,
  input wire [7:0] start_sample_setup_ff,
  input wire [7:0] own_slave_address_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Same-address writes only
  wire own_wr = reg_wr && reg_addr == 8'hdf;
  chk_flags_paired: assert property (intr_set_ff == addr_match_ff) else $error("flags split");
  chk_match_equal: assert property (addr_match_ff |-> addr_byte_valid_ff &&
    addr_byte_ff[7:1] == own_slave_address_ff[7:1]) else $error("bad match");
  chk_miss_silent: assert property (addr_byte_valid_ff &&
    addr_byte_ff[7:1] != own_slave_address_ff[7:1] |-> !addr_match_ff) else $error("false match");
  chk_addr_write: assert property (own_wr |=>
    own_slave_address_ff == ($past(reg_wdata) & 8'hfe)) else $error("own address");
  chk_addr_kept: assert property (!own_wr |=> $stable(own_slave_address_ff)) else $error("address moved");
  chk_setup_write: assert property (reg_wr && reg_addr == 8'hdb |=>
    start_sample_setup_ff == $past(reg_wdata)) else $error("setup");
  chk_setup_kept: assert property (!(reg_wr && reg_addr == 8'hdb) |=>
    $stable(start_sample_setup_ff)) else $error("setup moved");
  chk_master_quiet: assert property (!slave_mode [*3] |-> !start_valid_ff) else $error("master start");
  chk_start_lines: assert property (start_valid_ff |->
    $past(!sda_in, 3) && $past(scl_in, 3)) else $error("start lines");
  cover property (start_valid_ff);
  cover property (addr_match_ff);
  cover property (addr_byte_valid_ff && !addr_match_ff);
endmodule
bind iasf_top iasf_chk i_chk (
  .mclk(mclk),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .slave_mode(slave_mode),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .start_valid_ff(start_valid_ff),
  .intr_set_ff(intr_set_ff),
  .addr_match_ff(addr_match_ff),
  .addr_byte_ff(addr_byte_ff),
  .addr_byte_valid_ff(addr_byte_valid_ff),
  .start_sample_setup_ff(start_sample_setup_ff),
  .own_slave_address_ff(own_slave_address_ff)
);

// ===== sim/test_i2c_slave_addr_start_filter.sv
// Bench for the address match and START filter
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t bad %h", $time, a); end end
module test_i2c_slave_addr_start_filter;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg slave_mode = 1'b1;
  reg [7:0] last_b;
  wire scl_in, sda_in, start_valid_ff, intr_set_ff, addr_match_ff, addr_byte_valid_ff;
  wire [7:0] reg_rdata_ff, addr_byte_ff, start_sample_setup_ff, own_slave_address_ff;
  integer error_cnt = 0, compares = 0, cyc = 0, n_sv = 0, n_m = 0, n_i = 0;
  always #2.5 mclk = ~mclk;
  iasf_top i_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff),
    .slave_mode(slave_mode),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_valid_ff(start_valid_ff),
    .intr_set_ff(intr_set_ff),
    .addr_match_ff(addr_match_ff),
    .addr_byte_ff(addr_byte_ff),
    .addr_byte_valid_ff(addr_byte_valid_ff),
    .start_sample_setup_ff(start_sample_setup_ff),
    .own_slave_address_ff(own_slave_address_ff)
  );
  iasf_bus_model i_bus (.scl(scl_in), .sda(sda_in));
  // Pulse counts and hang ceiling
  always @(posedge mclk) begin
    cyc++;
    if (start_valid_ff === 1'b1) n_sv++;
    if (addr_match_ff === 1'b1) n_m++;
    if (intr_set_ff === 1'b1) n_i++;
    if (addr_byte_valid_ff === 1'b1) last_b = addr_byte_ff;
    if (cyc == 4000) begin
      error_cnt++;
      give_verdict;
    end
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk) #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk) #1 reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge mclk) #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk) #1 reg_rd = 1'b0;
      `CHK(reg_rdata_ff, e)
    end
  endtask
  // Program setup, send one frame, count pulses
  task run(input [7:0] s, input integer h, input [7:0] b, input integer sv, input integer m);
    begin
      wr(8'hdb, s);
      n_sv = 0;
      n_m = 0;
      n_i = 0;
      last_b = 8'h00;
      i_bus.frame(b, h);
      repeat (20) @(posedge mclk);
      `CHK(n_sv, sv)
      `CHK(n_m, m)
      `CHK(n_i, m)
      if (sv == 1) `CHK(last_b, b)
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    rd(8'hdb, 8'h00);
    rd(8'hdf, 8'h00);
    wr(8'hdf, 8'ha5);
    rd(8'hdf, 8'ha4);
    rd(8'hde, 8'h00);
    // Hold times chosen so one sample more or less flips the result
    run(8'h00, 11, 8'ha4, 1, 1);
    run(8'h80, 11, 8'ha4, 1, 1);
    run(8'h83, 21, 8'ha4, 0, 0);
    run(8'h83, 26, 8'ha5, 1, 1);
    run(8'h7f, 11, 8'h26, 1, 0);
    run(8'hff, 646, 8'ha4, 1, 1);
    run(8'hff, 641, 8'ha4, 0, 0);
    rd(8'hdb, 8'hff);
    `CHK(start_sample_setup_ff, 8'hff)
    @(posedge mclk) #1 slave_mode = 1'b0;
    run(8'h00, 60, 8'ha4, 0, 0);
    `CHK(own_slave_address_ff, 8'ha4)
    give_verdict;
  end
endmodule

// ===== verilog/iasf_defs.vh
// Constants for the I2C slave address match and START filter block
`ifndef IASF_DEFS_VH
`define IASF_DEFS_VH
`define IASF_SETUP_OFFSET 8'hdb
`define IASF_ADDR_OFFSET 8'hdf
`define IASF_SETUP_RESET 8'h00
`define IASF_ADDR_RESET 8'h00
`define IASF_SETUP_EN_BIT 7
`define IASF_SETUP_CNT_MSB 6
`define IASF_ADDR_MSB 7
`define IASF_ADDR_LSB 1
`define IASF_SAMPLE_GAP 1
`endif

// ===== verilog/iasf_sync.v
// Two-flop synchroniser for one bit
`timescale 1ns/10ps
module iasf_sync (
  input wire mclk,
  input wire rst_n,
  input wire din,
  output reg dout_ff
);
  reg meta_ff; // First stage, read only by second

  // ****************
  // Sync chain
  // ****************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      dout_ff <= 1'b1;
    end else begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end
endmodule

// ===== verilog/iasf_top.v
// I2C slave address match and START validation filter
`timescale 1ns/10ps
`include "iasf_defs.vh"
// Behaviour
// - Store writable 7-bit own address bits 7:1
// - Address match sets interrupt and match flags
// - Engine never writes address; ignored in master
// - SDA fall with SCL high starts candidate
// - Sample lines; validate then receive address
// - Enable clear: one sample after one period
// - Enable set: count plus one samples
// - Samples spaced one oscillator period
// - Setup: enable bit 7, count 6:0
// - Both registers reset to zero
module iasf_top (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  input wire slave_mode,
  input wire scl_in,
  input wire sda_in,
  output reg start_valid_ff,
  output reg intr_set_ff,
  output reg addr_match_ff,
  output reg [7:0] addr_byte_ff,
  output reg addr_byte_valid_ff,
  output reg [7:0] start_sample_setup_ff,
  output reg [7:0] own_slave_address_ff
);
  // ****************
  // States
  // ****************
  localparam ST_IDLE = 4'b0001; // Watching for SDA fall
  localparam ST_SAMP = 4'b0010; // Validating START
  localparam ST_ADDR = 4'b0100; // Shifting address byte
  localparam ST_WAIT = 4'b1000; // Wait for next START

  reg rst_a_ff; // Reset sync stage 1
  reg rst_n_ff; // Synced reset
  wire [1:0] pin_raw; // Raw pins, SCL in the high bit
  wire [1:0] pin_s; // Pins after two flops
  genvar gi; // Pin index for the sync chains
  wire scl_s; // Synced SCL
  wire sda_s; // Synced SDA
  reg scl_d_ff; // Previous SCL
  reg sda_d_ff; // Previous SDA
  reg [3:0] state_ff; // Current state
  reg [3:0] nxt_state;
  reg [7:0] cnt_ff; // Samples left
  reg [7:0] nxt_cnt;
  reg [7:0] shift_ff; // Address shifter
  reg [7:0] nxt_shift;
  reg [3:0] bits_ff; // Bits received
  reg [3:0] nxt_bits;
  wire sda_fall; // SDA edge while SCL high
  wire scl_rise; // SCL rising edge
  wire [7:0] first_cnt; // Samples to take

  // ****************
  // Reset release
  // ****************
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  // ****************
  // Pin sync
  // ****************
  // One two-flop chain per bus pin
  assign pin_raw = {scl_in, sda_in};
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
      iasf_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n_ff),
        .din(pin_raw[gi]),
        .dout_ff(pin_s[gi])
      );
    end
  endgenerate
  assign scl_s = pin_s[1]; // Clock line
  assign sda_s = pin_s[0]; // Data line

  // Edge detect; history resets high so no false edge
  assign sda_fall = sda_d_ff & ~sda_s & scl_s & scl_d_ff;
  assign scl_rise = ~scl_d_ff & scl_s;
  // One sample when disabled, else field plus one
  assign first_cnt = start_sample_setup_ff[`IASF_SETUP_EN_BIT] ?
    ({1'b0, start_sample_setup_ff[`IASF_SETUP_CNT_MSB:0]} + 8'h01) : 8'h01;

  // ****************
  // Registers, firmware only
  // ****************
  always @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      start_sample_setup_ff <= `IASF_SETUP_RESET;
      own_slave_address_ff <= `IASF_ADDR_RESET;
      reg_rdata_ff <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `IASF_SETUP_OFFSET)
        start_sample_setup_ff <= reg_wdata;
      // Bit 0 of the own address always kept zero
      if (reg_wr && reg_addr == `IASF_ADDR_OFFSET)
        own_slave_address_ff <= {reg_wdata[7:1], 1'b0};
      // Read data held until the next read strobe
      if (reg_rd) begin
        case (reg_addr)
          `IASF_SETUP_OFFSET: reg_rdata_ff <= start_sample_setup_ff;
          `IASF_ADDR_OFFSET: reg_rdata_ff <= own_slave_address_ff;
          default: reg_rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // ****************
  // Next state logic
  // ****************
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    case (state_ff)
      ST_IDLE: begin
        // Candidate START only in slave mode
        if (slave_mode && sda_fall) begin
          nxt_state = ST_SAMP;
          nxt_cnt = first_cnt;
        end
      end
      ST_SAMP: begin
        // One sample per mclk period
        // Data high, clock low or master: drop candidate
        if (!slave_mode || sda_s || !scl_s) begin
          nxt_state = ST_IDLE;
        end else if (cnt_ff == 8'h01) begin
          // Last sample passed, start the address byte
          nxt_state = ST_ADDR;
          nxt_bits = 4'h0;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_ADDR: begin
        // Bits sampled on SCL rising edges
        if (!slave_mode) begin
          nxt_state = ST_IDLE;
        end else if (sda_fall) begin
          nxt_state = ST_SAMP;
          nxt_cnt = first_cnt;
        end else if (scl_rise) begin
          nxt_shift = {shift_ff[6:0], sda_s};
          nxt_bits = bits_ff + 4'h1;
          if (bits_ff == 4'h7)
            nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Byte done; only a new START restarts
        if (!slave_mode)
          nxt_state = ST_IDLE;
        else if (sda_fall) begin
          nxt_state = ST_SAMP;
          nxt_cnt = first_cnt;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ****************
  // State and outputs
  // ****************
  always @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      shift_ff <= 8'h00;
      bits_ff <= 4'h0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      start_valid_ff <= 1'b0;
      intr_set_ff <= 1'b0;
      addr_match_ff <= 1'b0;
      addr_byte_ff <= 8'h00;
      addr_byte_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      // Edge history for the detectors
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      // Pulse when the last sample passes
      start_valid_ff <= (state_ff == ST_SAMP) && (nxt_state == ST_ADDR);
      // Byte hand-over pulse and data
      addr_byte_valid_ff <= (state_ff == ST_ADDR) && (nxt_state == ST_WAIT);
      if ((state_ff == ST_ADDR) && (nxt_state == ST_WAIT))
        addr_byte_ff <= nxt_shift;
      // Pulse both flags on a full 7-bit match
      intr_set_ff <= (state_ff == ST_ADDR) && (nxt_state == ST_WAIT) &&
        (nxt_shift[7:1] == own_slave_address_ff[`IASF_ADDR_MSB:`IASF_ADDR_LSB]);
      addr_match_ff <= (state_ff == ST_ADDR) && (nxt_state == ST_WAIT) &&
        (nxt_shift[7:1] == own_slave_address_ff[`IASF_ADDR_MSB:`IASF_ADDR_LSB]);
    end
  end
endmodule
